// ---- hdl/qlm_consts.vh ----
// Purpose: shared constants of the io queue list manager
// Assumes: 48-bit memory words, 20-bit word addresses
// Notes: apb offsets and io_command_block word offsets are local choices
`ifndef QLM_CONSTS_VH
`define QLM_CONSTS_VH
// memory word and address
`define QLM_WORD_W 48
`define QLM_ADDR_W 20
// command queue header word offsets
`define QLM_HDR_CW 20'h0_0000
`define QLM_HDR_HEAD 20'h0_0001
`define QLM_HDR_TAIL 20'h0_0002
`define QLM_HDR_HORIZONTAL_HEAD_POINTER 20'h0_0003
`define QLM_HDR_HQL 20'h0_0004
// io command block word offsets (arbitrary defaults)
`define QLM_IO_COMMAND_BLOCK_SELF 20'h0_0000
`define QLM_IO_COMMAND_BLOCK_NEXT 20'h0_0001
// queue control word fields
`define QLM_CW_SUSP 0
`define QLM_CW_WAIT 1
`define QLM_CW_HQP 2
`define QLM_CW_LIM_LO 8
`define QLM_CW_ACT_LO 16
`define QLM_CW_INA_LO 24
`define QLM_CNT_W 8
`define QLM_CNT_ONE 8'h01
`define QLM_REMOVED_MARK 48'h0000_0000_0001
// apb register byte offsets
`define QLM_A_CMD 12'h000
`define QLM_A_HDR 12'h004
`define QLM_A_BLK 12'h008
`define QLM_A_RES 12'h00C
`define QLM_A_CTRL 12'h010
`define QLM_A_STAT 12'h014
`define QLM_A_LAST 12'h018
// command codes
`define QLM_OP_START 2'h1
`define QLM_OP_COMPLETE 2'h2
// outcome codes
`define QLM_OC_NONE 3'h0
`define QLM_OC_STARTED 3'h1
`define QLM_OC_REFUSED 3'h2
`define QLM_OC_NOWORK 3'h3
`define QLM_OC_QUEUED 3'h4
`define QLM_OC_BUSY 3'h5
`define QLM_OC_DONE 3'h6
`endif

// ---- hdl/qlm_mem_port.v ----
// Purpose: single outstanding memory request holder
// Assumes: memory answers each request with one i_mem_ack pulse
// Notes: request fields stay stable from req rise to ack
`timescale 1ns/10ps
`default_nettype none
`include "qlm_consts.vh"
module qlm_mem_port (
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // from sequencer
  input wire i_start,
  input wire i_we,
  input wire [`QLM_ADDR_W-1:0] i_addr,
  input wire [`QLM_WORD_W-1:0] i_wdata,
  output reg o_done,
  output reg [`QLM_WORD_W-1:0] o_rdata,
  // memory side
  output reg o_mem_req,
  output reg o_mem_we,
  output reg [`QLM_ADDR_W-1:0] o_mem_addr,
  output reg [`QLM_WORD_W-1:0] o_mem_wdata,
  input wire i_mem_ack,
  input wire [`QLM_WORD_W-1:0] i_mem_rdata
);
  // latch request, drop it on ack and return read data
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= {`QLM_ADDR_W{1'b0}};
      o_mem_wdata <= {`QLM_WORD_W{1'b0}};
      o_done <= 1'b0;
      o_rdata <= {`QLM_WORD_W{1'b0}};
    end else begin
      o_done <= 1'b0;
      if (o_mem_req && i_mem_ack) begin
        o_mem_req <= 1'b0;
        o_done <= 1'b1;
        o_rdata <= i_mem_rdata;
      end else if (i_start && !o_mem_req) begin
        o_mem_req <= 1'b1;
        o_mem_we <= i_we;
        o_mem_addr <= i_addr;
        o_mem_wdata <= i_wdata;
      end
    end
  end
endmodule // qlm_mem_port
`default_nettype wire

// ---- hdl/qlm_apb_regs.v ----
// Purpose: apb slave holding the command and control registers
// Assumes: 32-bit apb, no wait state on any access
// Notes: command writes while busy are ignored
`timescale 1ns/10ps
`default_nettype none
`include "qlm_consts.vh"
module qlm_apb_regs (
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // apb
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  // to sequencer
  output reg o_go,
  output reg [1:0] o_op,
  output reg [`QLM_ADDR_W-1:0] o_hdr,
  output reg [`QLM_ADDR_W-1:0] o_blk,
  output reg [`QLM_ADDR_W-1:0] o_res,
  output reg [3:0] o_ctrl,
  // status from sequencer
  input wire i_busy,
  input wire [2:0] i_outcome,
  input wire [7:0] i_starts,
  input wire [`QLM_ADDR_W-1:0] i_last
);
  wire setup;
  wire wr;
  reg [31:0] rd_val;
  reg mapped;
  assign setup = i_psel && !i_penable;
  assign wr = i_psel && i_penable && o_pready && i_pwrite;
  // read mux and address decode
  always @* begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    case (i_paddr)
      `QLM_A_CMD: rd_val = {30'h0000_0000, o_op};
      `QLM_A_HDR: rd_val = {12'h000, o_hdr};
      `QLM_A_BLK: rd_val = {12'h000, o_blk};
      `QLM_A_RES: rd_val = {12'h000, o_res};
      `QLM_A_CTRL: rd_val = {28'h000_0000, o_ctrl};
      `QLM_A_STAT: rd_val = {20'h0_0000, i_starts, i_outcome, i_busy};
      `QLM_A_LAST: rd_val = {12'h000, i_last};
      default: mapped = 1'b0;
    endcase
  end
  // ready one cycle after setup; write lands on the access edge
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_go <= 1'b0;
      o_op <= 2'h0;
      o_hdr <= {`QLM_ADDR_W{1'b0}};
      o_blk <= {`QLM_ADDR_W{1'b0}};
      o_res <= {`QLM_ADDR_W{1'b0}};
      o_ctrl <= 4'h0;
    end else begin
      o_go <= 1'b0;
      o_pready <= setup;
      o_pslverr <= setup && !mapped;
      o_prdata <= (setup && !i_pwrite) ? rd_val : 32'h0000_0000;
      if (wr) begin
        case (i_paddr)
          `QLM_A_CMD: begin
            if (!i_busy) begin // busy sequencer keeps its job
              o_op <= i_pwdata[1:0];
              o_go <= 1'b1;
            end
          end
          `QLM_A_HDR: o_hdr <= i_pwdata[`QLM_ADDR_W-1:0];
          `QLM_A_BLK: o_blk <= i_pwdata[`QLM_ADDR_W-1:0];
          `QLM_A_RES: o_res <= i_pwdata[`QLM_ADDR_W-1:0];
          `QLM_A_CTRL: o_ctrl <= i_pwdata[3:0];
          default: o_ctrl <= o_ctrl;
        endcase
      end
    end
  end
endmodule // qlm_apb_regs
`default_nettype wire

// ---- hdl/qlm_queue_mgr.v ----
// Purpose: command, horizontal and result queue list manager
// Assumes: memory shared with host software, one request at a time
// Notes: one sequencer
// Notes on behaviour
// [RULE_01] suspended queue starts only immediate commands
// [RULE_02] error or suspend-all completion sets suspended; the code skips suspend-all while ign_susp is set
// [RULE_03] waiting bit mirrors horizontal linkage
// [RULE_04] link horizontally only with present bit
// [RULE_05] software zeroes reserved control bits
// [RULE_06] active count never exceeds active limit
// [RULE_07] active and inactive counts track blocks
// [RULE_08] software loads present bit, limit, mark
// [RULE_09] head link zero or first block
// [RULE_10] tail link zero or last block
// [RULE_11] never write horizontal head pointer word
// [RULE_12] maintain horizontal link word four
// [RULE_13] busy path queues command queue horizontally
// [RULE_14] walk to horizontal tail, append there
// [RULE_15] after completion walk horizontal queue, restart
// [RULE_16] horizontal array header word is ignored
// [RULE_17] horizontal head entries zero or first header
// [RULE_18] result queue is last in first out
// [RULE_19] swap result head, then write next link
// [RULE_20] software drains result queue by swap
// [RULE_21] software creates and clears result array
// [RULE_22] dequeue copies next link, marks block
// [RULE_23] result head exchange is locked
`timescale 1ns/10ps
`default_nettype none
`include "qlm_consts.vh"
module qlm_queue_mgr (
  // clock and reset
  input wire i_clock,
  input wire i_rst_n,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // path processor status pin
  input wire i_path_busy,
  // memory requestor
  output wire o_mem_req,
  output wire o_mem_we,
  output reg o_mem_lock,
  output wire [`QLM_ADDR_W-1:0] o_mem_addr,
  output wire [`QLM_WORD_W-1:0] o_mem_wdata,
  input wire i_mem_ack,
  input wire [`QLM_WORD_W-1:0] i_mem_rdata,
  // started command block
  output reg o_start,
  output reg [`QLM_ADDR_W-1:0] o_start_blk
);
  localparam [4:0] S_IDLE = 5'd0, S_RDCW = 5'd1, S_CHK = 5'd2,
    S_RDHQP = 5'd3, S_RDHE = 5'd4, S_WALK = 5'd5, S_LINK = 5'd6,
    S_SETW = 5'd7, S_RDHEAD = 5'd8, S_RDNEXT = 5'd9, S_WRHEAD = 5'd10,
    S_WRMARK = 5'd11, S_WRTAIL = 5'd12, S_WRCW = 5'd13, C_RDCW = 5'd14,
    C_WRCW = 5'd15, C_RDSELF = 5'd16, C_XCHG = 5'd17, C_XCHGW = 5'd18,
    C_WRNEXT = 5'd19, R_RDHQP = 5'd20, R_RDHE = 5'd21, R_RDQL = 5'd22,
    R_WRHE = 5'd23, R_CLRQL = 5'd24, R_RDQCW = 5'd25, R_WRQCW = 5'd26,
    S_DONE = 5'd27;

  // descriptor address part; zero word means empty
  function [`QLM_ADDR_W-1:0] dd_addr;
    input [`QLM_WORD_W-1:0] w;
    begin
      dd_addr = w[`QLM_ADDR_W-1:0];
    end
  endfunction
  // descriptor built for a header or block address
  function [`QLM_WORD_W-1:0] dd_make;
    input [`QLM_ADDR_W-1:0] a;
    begin
      dd_make = {{(`QLM_WORD_W-`QLM_ADDR_W){1'b0}}, a};
    end
  endfunction

  wire go;
  wire [1:0] op;
  wire [`QLM_ADDR_W-1:0] r_hdr;
  wire [`QLM_ADDR_W-1:0] r_blk;
  wire [`QLM_ADDR_W-1:0] r_res;
  wire [3:0] ctrl;
  wire mem_done;
  wire [`QLM_WORD_W-1:0] mem_rdata;
  reg [4:0] st_reg;
  reg wait_reg;
  reg resume_reg;
  reg [2:0] outcome_reg;
  reg [7:0] starts_reg;
  reg [`QLM_ADDR_W-1:0] hdr_reg;
  reg [`QLM_ADDR_W-1:0] ent_reg;
  reg [`QLM_ADDR_W-1:0] cur_reg;
  reg [`QLM_ADDR_W-1:0] blk_reg;
  reg [`QLM_WORD_W-1:0] cw_reg;
  reg [`QLM_WORD_W-1:0] nxt_reg;
  reg [`QLM_WORD_W-1:0] self_reg;
  reg [2:0] busy_sync_reg;
  reg path_busy_reg;
  reg acc;
  reg acc_we;
  reg [`QLM_ADDR_W-1:0] acc_addr;
  reg [`QLM_WORD_W-1:0] acc_wdata;
  wire suspend_all;
  wire immediate;
  wire ign_susp;
  wire io_error;
  wire [`QLM_CNT_W-1:0] lim;
  wire [`QLM_CNT_W-1:0] act;
  wire [`QLM_CNT_W-1:0] ina;
  wire busy;
  wire can_more;
  wire new_susp;

  assign suspend_all = ctrl[0];
  assign immediate = ctrl[1];
  assign ign_susp = ctrl[2];
  assign io_error = ctrl[3];
  assign lim = cw_reg[`QLM_CW_LIM_LO +: `QLM_CNT_W];
  assign act = cw_reg[`QLM_CW_ACT_LO +: `QLM_CNT_W];
  assign ina = cw_reg[`QLM_CW_INA_LO +: `QLM_CNT_W];
  assign busy = (st_reg != S_IDLE);
  assign new_susp = io_error || (suspend_all && !ign_susp); // [RULE_02]
  assign can_more = !cw_reg[`QLM_CW_SUSP] && (ina != 8'h00)
    && (act < lim);

  qlm_apb_regs u_regs (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_go(go),
    .o_op(op),
    .o_hdr(r_hdr),
    .o_blk(r_blk),
    .o_res(r_res),
    .o_ctrl(ctrl),
    .i_busy(busy),
    .i_outcome(outcome_reg),
    .i_starts(starts_reg),
    .i_last(o_start_blk)
  );

  qlm_mem_port u_mem (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_start(acc && !wait_reg),
    .i_we(acc_we),
    .i_addr(acc_addr),
    .i_wdata(acc_wdata),
    .o_done(mem_done),
    .o_rdata(mem_rdata),
    .o_mem_req(o_mem_req),
    .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata),
    .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata)
  );

  // path busy pin: three flops, change taken when last two agree
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      busy_sync_reg <= 3'h0;
      path_busy_reg <= 1'b0;
    end else begin
      busy_sync_reg <= {busy_sync_reg[1:0], i_path_busy};
      if (busy_sync_reg[2] == busy_sync_reg[1])
        path_busy_reg <= busy_sync_reg[2];
    end
  end

  // memory access of each state; word three is never a write target
  always @* begin
    acc = 1'b1;
    acc_we = 1'b0;
    acc_addr = hdr_reg + `QLM_HDR_CW;
    acc_wdata = {`QLM_WORD_W{1'b0}};
    case (st_reg)
      S_RDCW, C_RDCW: acc_addr = hdr_reg + `QLM_HDR_CW;
      S_RDHQP, R_RDHQP: acc_addr = hdr_reg + `QLM_HDR_HORIZONTAL_HEAD_POINTER; // [RULE_11]
      S_RDHE, R_RDHE: acc_addr = ent_reg;
      S_WALK: acc_addr = cur_reg;
      S_LINK: begin
        acc_we = 1'b1;
        acc_addr = cur_reg;
        acc_wdata = dd_make(hdr_reg); // [RULE_14]
      end
      S_SETW: begin
        acc_we = 1'b1;
        acc_wdata = cw_reg | (48'h0000_0000_0001 << `QLM_CW_WAIT);
      end
      S_RDHEAD: acc_addr = hdr_reg + `QLM_HDR_HEAD;
      S_RDNEXT: acc_addr = blk_reg + `QLM_IO_COMMAND_BLOCK_NEXT;
      S_WRHEAD: begin
        acc_we = 1'b1;
        acc_addr = hdr_reg + `QLM_HDR_HEAD;
        acc_wdata = nxt_reg; // [RULE_22] [RULE_09]
      end
      S_WRMARK: begin
        acc_we = 1'b1;
        acc_addr = blk_reg + `QLM_IO_COMMAND_BLOCK_NEXT;
        acc_wdata = `QLM_REMOVED_MARK; // [RULE_22]
      end
      S_WRTAIL: begin
        acc_we = 1'b1;
        acc_addr = hdr_reg + `QLM_HDR_TAIL; // [RULE_10]
      end
      S_WRCW, C_WRCW, R_WRQCW: begin
        acc_we = 1'b1;
        acc_wdata = cw_reg;
      end
      C_RDSELF: acc_addr = blk_reg + `QLM_IO_COMMAND_BLOCK_SELF;
      C_XCHG: acc_addr = r_res; // [RULE_23]
      C_XCHGW: begin
        acc_we = 1'b1;
        acc_addr = r_res;
        acc_wdata = self_reg; // [RULE_19] [RULE_18]
      end
      C_WRNEXT: begin
        acc_we = 1'b1;
        acc_addr = blk_reg + `QLM_IO_COMMAND_BLOCK_NEXT;
        acc_wdata = nxt_reg; // [RULE_19]
      end
      R_RDQL: acc_addr = cur_reg + `QLM_HDR_HQL;
      R_WRHE: begin
        acc_we = 1'b1;
        acc_addr = ent_reg;
        acc_wdata = nxt_reg; // [RULE_17]
      end
      R_CLRQL: begin
        acc_we = 1'b1;
        acc_addr = cur_reg + `QLM_HDR_HQL; // [RULE_12]
      end
      R_RDQCW: acc_addr = cur_reg;
      default: acc = 1'b0;
    endcase
    if (path_busy_reg && st_reg == R_RDHE) acc = 1'b0; // no stale ack
  end

  // sequencer: one memory word per access state, advance on completion
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_reg <= S_IDLE;
      wait_reg <= 1'b0;
      resume_reg <= 1'b0;
      outcome_reg <= `QLM_OC_NONE;
      starts_reg <= 8'h00;
      hdr_reg <= {`QLM_ADDR_W{1'b0}};
      ent_reg <= {`QLM_ADDR_W{1'b0}};
      cur_reg <= {`QLM_ADDR_W{1'b0}};
      blk_reg <= {`QLM_ADDR_W{1'b0}};
      cw_reg <= {`QLM_WORD_W{1'b0}};
      nxt_reg <= {`QLM_WORD_W{1'b0}};
      self_reg <= {`QLM_WORD_W{1'b0}};
      o_mem_lock <= 1'b0;
      o_start <= 1'b0;
      o_start_blk <= {`QLM_ADDR_W{1'b0}};
    end else begin
      o_start <= 1'b0;
      if (acc && !wait_reg)
        wait_reg <= 1'b1;
      if (mem_done)
        wait_reg <= 1'b0;
      case (st_reg)
        S_IDLE: begin
          resume_reg <= 1'b0;
          hdr_reg <= r_hdr;
          blk_reg <= r_blk;
          if (go && op == `QLM_OP_START)
            st_reg <= S_RDCW;
          else if (go && op == `QLM_OP_COMPLETE)
            st_reg <= C_RDCW;
        end
        S_RDCW: if (mem_done) begin
          cw_reg <= mem_rdata;
          st_reg <= S_CHK;
        end
        S_CHK: begin
          if (cw_reg[`QLM_CW_SUSP] && !immediate) begin // [RULE_01]
            outcome_reg <= `QLM_OC_REFUSED;
            st_reg <= resume_reg ? R_RDHE : S_DONE;
          end else if (ina == 8'h00 || act >= lim) begin // [RULE_06]
            outcome_reg <= `QLM_OC_NOWORK;
            st_reg <= resume_reg ? R_RDHE : S_DONE;
          end else if (path_busy_reg) begin
            outcome_reg <= `QLM_OC_BUSY;
            // only a present queue not yet linked joins the path queue
            if (cw_reg[`QLM_CW_HQP] && !cw_reg[`QLM_CW_WAIT]) // [RULE_04]
              st_reg <= S_RDHQP; // [RULE_13]
            else
              st_reg <= S_DONE;
          end else begin
            st_reg <= S_RDHEAD;
          end
        end
        S_RDHQP: if (mem_done) begin
          ent_reg <= dd_addr(mem_rdata);
          st_reg <= S_RDHE;
        end
        S_RDHE: if (mem_done) begin
          cur_reg <= (mem_rdata == {`QLM_WORD_W{1'b0}}) ? ent_reg
            : dd_addr(mem_rdata) + `QLM_HDR_HQL;
          st_reg <= (mem_rdata == {`QLM_WORD_W{1'b0}}) ? S_LINK : S_WALK;
        end
        S_WALK: if (mem_done) begin
          // follow link words until the last queue of the chain
          if (mem_data_zero(mem_rdata))
            st_reg <= S_LINK; // [RULE_14]
          else
            cur_reg <= dd_addr(mem_rdata) + `QLM_HDR_HQL;
        end
        S_LINK: if (mem_done) st_reg <= S_SETW;
        S_SETW: if (mem_done) begin
          outcome_reg <= `QLM_OC_QUEUED; // [RULE_03]
          st_reg <= S_DONE;
        end
        S_RDHEAD: if (mem_done) begin
          blk_reg <= dd_addr(mem_rdata);
          st_reg <= S_RDNEXT;
        end
        S_RDNEXT: if (mem_done) begin
          nxt_reg <= mem_rdata;
          st_reg <= S_WRHEAD;
        end
        S_WRHEAD: if (mem_done) st_reg <= S_WRMARK;
        S_WRMARK: if (mem_done) begin
          st_reg <= mem_data_zero(nxt_reg) ? S_WRTAIL : S_WRCW;
          cw_reg[`QLM_CW_ACT_LO +: `QLM_CNT_W] <= act + `QLM_CNT_ONE; // [RULE_07]
          cw_reg[`QLM_CW_INA_LO +: `QLM_CNT_W] <= ina - `QLM_CNT_ONE; // [RULE_07]
        end
        S_WRTAIL: if (mem_done) st_reg <= S_WRCW;
        S_WRCW: if (mem_done) begin
          o_start <= 1'b1;
          o_start_blk <= blk_reg;
          starts_reg <= starts_reg + 8'h01;
          outcome_reg <= `QLM_OC_STARTED;
          // a queue taken from the path queue runs up to its limit
          st_reg <= resume_reg ? S_RDCW : S_DONE; // [RULE_15]
        end
        C_RDCW: if (mem_done) begin
          cw_reg <= mem_rdata;
          if (new_susp)
            cw_reg[`QLM_CW_SUSP] <= 1'b1; // [RULE_02]
          cw_reg[`QLM_CW_ACT_LO +: `QLM_CNT_W] <=
            mem_rdata[`QLM_CW_ACT_LO +: `QLM_CNT_W] - `QLM_CNT_ONE; // [RULE_07]
          st_reg <= C_WRCW;
        end
        C_WRCW: if (mem_done) st_reg <= C_RDSELF;
        C_RDSELF: if (mem_done) begin
          self_reg <= mem_rdata;
          o_mem_lock <= 1'b1; // [RULE_23]
          st_reg <= C_XCHG;
        end
        C_XCHG: if (mem_done) begin
          nxt_reg <= mem_rdata;
          st_reg <= C_XCHGW;
        end
        C_XCHGW: if (mem_done) begin
          o_mem_lock <= 1'b0; // [RULE_23]
          st_reg <= C_WRNEXT;
        end
        C_WRNEXT: if (mem_done) begin
          outcome_reg <= `QLM_OC_DONE;
          if (can_more)
            st_reg <= S_RDCW;
          else if (cw_reg[`QLM_CW_HQP])
            st_reg <= R_RDHQP; // [RULE_15]
          else
            st_reg <= S_DONE;
        end
        R_RDHQP: if (mem_done) begin
          ent_reg <= dd_addr(mem_rdata);
          st_reg <= R_RDHE;
        end
        R_RDHE: begin
          // stop handing out queues once the path is busy again
          if (path_busy_reg && !wait_reg)
            st_reg <= S_DONE;
          else if (mem_done) begin
            cur_reg <= dd_addr(mem_rdata);
            st_reg <= mem_data_zero(mem_rdata) ? S_DONE : R_RDQL;
          end
        end
        R_RDQL: if (mem_done) begin
          nxt_reg <= mem_rdata;
          st_reg <= R_WRHE;
        end
        R_WRHE: if (mem_done) st_reg <= R_CLRQL;
        R_CLRQL: if (mem_done) st_reg <= R_RDQCW;
        R_RDQCW: if (mem_done) begin
          cw_reg <= mem_rdata;
          cw_reg[`QLM_CW_WAIT] <= 1'b0; // [RULE_03]
          hdr_reg <= cur_reg;
          st_reg <= R_WRQCW;
        end
        R_WRQCW: if (mem_done) begin
          resume_reg <= 1'b1;
          st_reg <= S_RDCW; // [RULE_15]
        end
        S_DONE: st_reg <= S_IDLE;
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // zero test shared by the link decisions of S_WALK, S_WRMARK and R_RDHE
  function mem_data_zero;
    input [`QLM_WORD_W-1:0] w;
    begin
      mem_data_zero = (w == {`QLM_WORD_W{1'b0}});
    end
  endfunction
endmodule // qlm_queue_mgr
`default_nettype wire

// ---- bench/qlm_properties.sv ----
// Purpose: port-level checks of the queue list manager
// Assumes: apb master and memory keep the hand-over timing
// Notes: shadows header and result addresses from apb writes
`timescale 1ns/10ps
`default_nettype none
`include "qlm_consts.vh"
module qlm_props (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // memory and start
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic o_mem_lock,
  input wire logic [`QLM_ADDR_W-1:0] o_mem_addr,
  input wire logic [`QLM_WORD_W-1:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic o_start,
  input wire logic [`QLM_ADDR_W-1:0] o_start_blk
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [`QLM_ADDR_W-1:0] hdr_reg;
  logic [`QLM_ADDR_W-1:0] res_reg;
  wire wr_acc = i_psel && i_penable && o_pready && i_pwrite;
  // shadow copies, since the checker cannot see the register bank
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      hdr_reg <= 20'h0;
      res_reg <= 20'h0;
    end else if (wr_acc && i_paddr == `QLM_A_HDR) begin
      hdr_reg <= i_pwdata[19:0];
    end else if (wr_acc && i_paddr == `QLM_A_RES) begin
      res_reg <= i_pwdata[19:0];
    end
  end
  a_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req &&
    $stable(o_mem_addr) && $stable(o_mem_we) && $stable(o_mem_wdata))
    else $error("memory request moved before ack");
  a_req_gap: assert property (o_mem_req && i_mem_ack |=> !o_mem_req [*2])
    else $error("memory request not dropped after ack");
  a_ready_one: assert property (i_psel && !i_penable |=>
    o_pready ##1 !o_pready)
    else $error("pready not one cycle after setup");
  a_bad_addr: assert property (i_psel && !i_penable |=>
    o_pslverr == ($past(i_paddr) > `QLM_A_LAST))
    else $error("slave error does not match address");
  a_horizontal_head_pointer_kept: assert property (
    o_mem_req && o_mem_we |-> o_mem_addr != hdr_reg + `QLM_HDR_HORIZONTAL_HEAD_POINTER)
    else $error("horizontal head pointer word written");
  a_lock_addr: assert property (
    o_mem_lock && o_mem_req |-> o_mem_addr == res_reg)
    else $error("locked access off the result head");
  a_lock_span: assert property (
    o_mem_lock && o_mem_req && !o_mem_we && i_mem_ack |=>
    o_mem_lock [*2] ##[1:600] (o_mem_lock && o_mem_req && o_mem_we))
    else $error("result head exchange not kept locked");
  a_start_blk: assert property ($changed(o_start_blk) |-> o_start)
    else $error("started block moved without a start");
endmodule // qlm_props
bind qlm_queue_mgr qlm_props u_props (.i_clock, .i_rst_n, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr,
  .o_mem_req, .o_mem_we, .o_mem_lock, .o_mem_addr, .o_mem_wdata,
  .i_mem_ack, .o_start, .o_start_blk);
`default_nettype wire

// ---- bench/qlm_mem_model.sv ----
// Purpose: shared main memory answering the queue manager
// Assumes: one request at a time, ack is a one-cycle pulse
// Notes: lat sets the answer delay; idle read bus toggles
`timescale 1ns/10ps
`default_nettype none
module qlm_mem_model (
  // clock
  input wire logic i_clock,
  // request
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [19:0] i_addr,
  input wire logic [47:0] i_wdata,
  // answer
  output logic o_ack = 1'b0,
  output logic [47:0] o_rdata = 48'h0
);
  logic [47:0] mem [0:255];
  int lat = 0;
  int cnt = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = 48'h0;
  // one port, so a locked exchange is never split by another access
  always @(posedge i_clock) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (cnt < lat) begin
        cnt <= cnt + 1;
      end else begin
        cnt <= 0;
        o_ack <= 1'b1;
        if (i_we) mem[i_addr[7:0]] <= i_wdata;
        else o_rdata <= mem[i_addr[7:0]];
      end
    end
  end
endmodule // qlm_mem_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// Purpose: regression bench for the queue list manager
// Assumes: memory model holds every queue structure
// Notes: software set-up is written straight into memory
`timescale 1ns/10ps
`default_nettype none
`include "qlm_consts.vh"
module tb_top;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic i_path_busy = 1'b0;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata, s;
  logic o_pready, o_mem_req, o_mem_we, i_mem_ack;
  logic [19:0] o_mem_addr, o_start_blk;
  logic [47:0] o_mem_wdata, i_mem_rdata;
  int err_total = 0;
  int total_checks = 0;
  // 200 MHz
  always #2.5 i_clock = ~i_clock;
  qlm_queue_mgr uut (.i_clock, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr(), .i_path_busy,
    .o_mem_req, .o_mem_we, .o_mem_lock(), .o_mem_addr, .o_mem_wdata,
    .i_mem_ack, .i_mem_rdata, .o_start(), .o_start_blk);
  qlm_mem_model u_mem (.i_clock, .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack),
    .o_rdata(i_mem_rdata));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one transfer, held until pready; an idle edge keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    s = o_prdata;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
  endtask
  // command, then poll status until the sequencer is idle
  task automatic run(input logic [1:0] op);
    apb(1'b1, `QLM_A_CMD, {30'h0, op});
    repeat (3) @(posedge i_clock);
    do begin
      apb(1'b0, `QLM_A_STAT, 32'h0);
    end while (s[0] !== 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b1;
    // queue at 10h: blocks 40h, 50h, 60h, limit 2
    for (int i = 0; i < 3; i++) begin
      u_mem.mem[8'h40 + 8'(i * 16)] = 48'h40 + 48'(i * 16);
      u_mem.mem[8'h41 + 8'(i * 16)] = (i < 2) ? 48'h50 + 48'(i * 16) : 48'h0;
    end
    u_mem.mem[8'h10] = 48'h0000_0300_0200;
    u_mem.mem[8'h11] = 48'h40;
    u_mem.mem[8'h12] = 48'h60;
    @(posedge i_clock);
    apb(1'b1, `QLM_A_HDR, 32'h10);
    apb(1'b1, `QLM_A_RES, 32'h80);
    apb(1'b1, `QLM_A_CTRL, 32'h0);
    apb(1'b0, 12'h01C, 32'h0);
    run(`QLM_OP_START);
    chk(s[3:1], `QLM_OC_STARTED);
    chk(o_start_blk, 20'h40);
    chk(u_mem.mem[8'h11], 48'h50);
    chk(u_mem.mem[8'h41], `QLM_REMOVED_MARK);
    run(`QLM_OP_START);
    run(`QLM_OP_START);
    chk(s[3:1], `QLM_OC_NOWORK);
    chk(u_mem.mem[8'h10], 48'h0000_0102_0200);
    $display("test 1 done");
    // slow memory; completion frees a slot and restarts 60h
    u_mem.lat = 2;
    apb(1'b1, `QLM_A_BLK, 32'h40);
    run(`QLM_OP_COMPLETE);
    chk(u_mem.mem[8'h80], 48'h40);
    chk(u_mem.mem[8'h41], 48'h0);
    chk(o_start_blk, 20'h60);
    chk(u_mem.mem[8'h12], 48'h0);
    chk(u_mem.mem[8'h10], 48'h0000_0002_0200);
    $display("test 2 done");
    apb(1'b1, `QLM_A_CTRL, 32'h8);
    apb(1'b1, `QLM_A_BLK, 32'h50);
    run(`QLM_OP_COMPLETE);
    chk(u_mem.mem[8'h80], 48'h50);
    chk(u_mem.mem[8'h51], 48'h40);
    chk(u_mem.mem[8'h10], 48'h0000_0001_0201);
    $display("test 3 done");
    // suspended queue takes only an immediate command
    u_mem.mem[8'h70] = 48'h70;
    u_mem.mem[8'h11] = 48'h70;
    u_mem.mem[8'h12] = 48'h70;
    u_mem.mem[8'h10] = 48'h0000_0101_0201;
    apb(1'b1, `QLM_A_CTRL, 32'h0);
    run(`QLM_OP_START);
    chk(s[3:1], `QLM_OC_REFUSED);
    apb(1'b1, `QLM_A_CTRL, 32'h2);
    run(`QLM_OP_START);
    chk(o_start_blk, 20'h70);
    $display("test 4 done");
    // busy path: queue 20h appended behind 10h
    i_path_busy <= 1'b1;
    u_mem.mem[8'h20] = 48'h0000_0100_0104;
    u_mem.mem[8'h21] = 48'h44;
    u_mem.mem[8'h23] = 48'h30;
    u_mem.mem[8'h30] = 48'h10;
    apb(1'b1, `QLM_A_HDR, 32'h20);
    run(`QLM_OP_START);
    chk(s[3:1], `QLM_OC_QUEUED);
    chk(u_mem.mem[8'h14], 48'h20);
    chk(u_mem.mem[8'h23], 48'h30);
    chk(u_mem.mem[8'h20][1], 1'b1);
    i_path_busy <= 1'b0;
    run(`QLM_OP_COMPLETE);
    chk(u_mem.mem[8'h30], 48'h0);
    chk(u_mem.mem[8'h14], 48'h0);
    chk(u_mem.mem[8'h10], 48'h0000_0002_0201);
    $display("test 5 done");
    tally_and_finish;
  end
  // hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    tally_and_finish;
  end
endmodule // tb_top
`default_nettype wire
